// File: unified_writeback_cache.sv
/*
  Unified instruction and data cache with write-through and write-back
  policies, posted write buffer and a half-rate external burst bus.
  Assumes the core request comes from logic on clk and is held until
  acknowledged; bus and snoop pins come from outside and are synchronised.
*/
// Operation
// - Write policy selectable between write-through and write-back.
// - Write-through: every store also issues an external write.
// - Write-back: hits stay in cache; writes only on miss, eviction, snoop.
// - One shared eight-kilobyte array for instructions and data.
// - Four ways per set, victim chosen least recently used.
// - Sixteen-byte lines, allocated only on read misses.
// - Valid bit per line, modified bit per double-word.
// - Eviction writes back only modified double-words.
// - Hits complete within one core clock cycle, except a write-through store hit, which waits while the write buffer is full.
// - Eight posted write buffers between core and bus.
// - Core runs at twice the bus clock rate.
// - Thirty-two-bit burst bus over a four-gigabyte address space.
`timescale 1ns/100ps
`include "cache_regs.svh"

module unified_writeback_cache (
    input wire logic clk,
    input wire logic reset,
    input wire logic policy_write_back,
    input wire logic core_req,
    input wire logic core_we,
    input wire logic [`ADDR_BITS-1:0] core_addr,
    input wire logic [`DATA_BITS-1:0] core_wdata,
    input wire logic [`BE_BITS-1:0] core_be,
    output logic core_ack_q,
    output logic [`DATA_BITS-1:0] core_rdata_q,
    output logic bus_clk_q,
    output logic bus_strobe_q,
    output logic bus_write_q,
    output logic bus_burst_q,
    output logic [`ADDR_BITS-1:0] bus_addr_q,
    output logic [`DATA_BITS-1:0] bus_wdata_q,
    output logic [`BE_BITS-1:0] bus_be_q,
    input wire logic bus_ready,
    input wire logic [`DATA_BITS-1:0] bus_rdata,
    input wire logic snoop_req,
    input wire logic [`ADDR_BITS-1:0] snoop_addr,
    output logic snoop_done_q
);
    // Shared array: 512 lines of four double-words
    logic [`DATA_BITS-1:0] data_q [`WORDS_TOTAL];
    logic [`TAG_BITS-1:0] tag_q [`LINES_TOTAL];
    logic [`LINES_TOTAL-1:0] valid_q;
    logic [`LINE_WORDS-1:0] dirty_q [`LINES_TOTAL];
    logic [`CACHE_WAYS*`WAY_BITS-1:0] lru_q [`CACHE_SETS];

    cache_pkg::cache_state_t state_q, state_d;
    cache_pkg::bus_state_t bstate_q;
    logic mode_q;
    logic [`IDX_BITS-1:0] miss_idx_q;
    logic [`TAG_BITS-1:0] miss_tag_q;
    logic [`WAY_BITS-1:0] miss_way_q;
    logic [`WORD_BITS-1:0] evict_word_q, evict_next;
    logic [`WORD_BITS-1:0] fill_cnt_q;
    logic snoop_flag_q, snoop_pend_q, fill_pend_q;
    logic rdy_m_q, rdy_s_q, snp_m_q, snp_s_q, snp_old_q;
    logic [`DATA_BITS-1:0] rdata_m_q, rdata_s_q;
    logic [`ADDR_BITS-1:0] saddr_m_q, saddr_s_q;

    // Lookup address: a pending snoop takes the tag port ahead of the core
    logic snoop_serve;
    logic [`ADDR_BITS-1:0] look_addr;
    logic [`IDX_BITS-1:0] lidx;
    logic [`TAG_BITS-1:0] ltag;
    logic [`WORD_BITS-1:0] lword;
    assign snoop_serve = (state_q == cache_pkg::c_idle) && snoop_pend_q;
    assign look_addr = snoop_serve ? saddr_s_q : core_addr;
    assign lidx = look_addr[`OFF_BITS +: `IDX_BITS];
    assign ltag = look_addr[`ADDR_BITS-1 -: `TAG_BITS];
    assign lword = look_addr[`WORD_BITS+1:2];

    // Tag compare in all four ways of the set
    logic [`IDX_BITS-1:0] lru_set;
    logic [`CACHE_WAYS-1:0] way_hit, set_valid;
    for (genvar w = 0; w < `CACHE_WAYS; w++) begin : g_way
        assign set_valid[w] = valid_q[{lru_set, 2'(w)}];
        assign way_hit[w] = valid_q[{lidx, 2'(w)}] && (tag_q[{lidx, 2'(w)}] == ltag);
    end
    logic any_hit;
    logic [`WAY_BITS-1:0] hit_way;
    assign any_hit = |way_hit;
    assign hit_way = way_hit[3] ? 2'h3 : way_hit[2] ? 2'h2 : way_hit[1] ? 2'h1 : 2'h0;

    // Byte merge of a store into the hit double-word
    logic [`WADDR_BITS-1:0] hit_waddr;
    logic [`DATA_BITS-1:0] hit_data, merged;
    assign hit_waddr = {lidx, hit_way, lword};
    assign hit_data = data_q[hit_waddr];
    for (genvar b = 0; b < `BE_BITS; b++) begin : g_byte
        assign merged[b*8 +: 8] = core_be[b] ? core_wdata[b*8 +: 8] : hit_data[b*8 +: 8];
    end

    // Replacement state of the set being looked up or filled
    logic [`WAY_BITS-1:0] touch_way, victim;
    logic [`CACHE_WAYS*`WAY_BITS-1:0] ages_next;
    assign lru_set = (state_q == cache_pkg::c_fill) ? miss_idx_q : lidx;
    assign touch_way = (state_q == cache_pkg::c_fill) ? miss_way_q : hit_way;

    lru_unit #(.WAYS(`CACHE_WAYS), .AGE_BITS(`WAY_BITS)) u_lru (
        .ages(lru_q[lru_set]),
        .valid(set_valid),
        .touch_way(touch_way),
        .victim(victim),
        .ages_next(ages_next)
    );

    // Line being evicted or filled
    logic [`LINE_BITS-1:0] eline;
    logic [`LINE_WORDS-1:0] edirty;
    logic [`ADDR_BITS-1:0] evict_addr;
    assign eline = {miss_idx_q, miss_way_q};
    assign edirty = dirty_q[eline];
    assign evict_addr = {tag_q[eline], miss_idx_q, evict_word_q, 2'h0};

    // Eight-entry posted write buffer toward the bus
    logic push_valid, wb_in_ready, wb_out_valid, wb_pop, wb_empty;
    logic [`WBUF_WIDTH-1:0] push_data, wb_out;
    write_buffer #(.WIDTH(`WBUF_WIDTH), .DEPTH(`WBUF_DEPTH)) u_wbuf (
        .clk(clk),
        .reset(reset),
        .in_valid(push_valid),
        .in_ready(wb_in_ready),
        .in_data(push_data),
        .out_valid(wb_out_valid),
        .out_ready(wb_pop),
        .out_data(wb_out),
        .empty(wb_empty)
    );

    // Bus runs on every second core cycle
    logic bus_en, bus_idle, fill_beat, fill_done;
    assign bus_en = bus_clk_q;
    assign bus_idle = (bstate_q == cache_pkg::b_idle) && !fill_pend_q;
    assign wb_pop = bus_en && (bstate_q == cache_pkg::b_idle) && !fill_pend_q && wb_out_valid;
    assign fill_beat = bus_en && (bstate_q == cache_pkg::b_read) && rdy_s_q;
    assign fill_done = fill_beat && (fill_cnt_q == `LAST_WORD);

    // Controller decisions for the current cycle
    logic ack_d, arr_we, dirty_or, touch_en, miss_take, invalidate;
    logic snoop_take, snoop_done_d, fill_req, fill_commit, evict_clear;
    always_comb begin
        state_d = state_q;
        ack_d = 1'b0;
        arr_we = 1'b0;
        dirty_or = 1'b0;
        touch_en = 1'b0;
        miss_take = 1'b0;
        invalidate = 1'b0;
        snoop_take = 1'b0;
        snoop_done_d = 1'b0;
        fill_req = 1'b0;
        fill_commit = 1'b0;
        evict_clear = 1'b0;
        evict_next = evict_word_q;
        push_valid = 1'b0;
        push_data = {core_addr, core_wdata, core_be};
        case (state_q)
            cache_pkg::c_idle: begin
                if (snoop_pend_q) begin
                    snoop_take = 1'b1;
                    // Another master needs the line: flush and drop it
                    if (any_hit) begin
                        miss_take = 1'b1;
                        invalidate = 1'b1;
                        state_d = cache_pkg::c_evict;
                    end else begin
                        snoop_done_d = 1'b1;
                    end
                end else if (core_req && !core_we && any_hit) begin
                    ack_d = 1'b1;
                    touch_en = 1'b1;
                end else if (core_req && !core_we) begin
                    // Read miss allocates over the victim
                    miss_take = 1'b1;
                    invalidate = 1'b1;
                    state_d = cache_pkg::c_evict;
                end else if (core_req && any_hit && mode_q) begin
                    // Write-back hit: cache only, mark the double-word
                    arr_we = 1'b1;
                    dirty_or = 1'b1;
                    touch_en = 1'b1;
                    ack_d = 1'b1;
                end else if (core_req) begin
                    // Write-through store or write miss: post it
                    // Write miss leaves the array untouched
                    push_valid = 1'b1;
                    if (wb_in_ready) begin
                        ack_d = 1'b1;
                        arr_we = any_hit;
                        touch_en = any_hit;
                    end
                end
            end
            cache_pkg::c_evict: begin
                push_valid = edirty[evict_word_q];
                push_data = {evict_addr, data_q[{eline, evict_word_q}], `FULL_BE};
                if (!push_valid || wb_in_ready) begin
                    evict_next = evict_word_q + 1'b1;
                    if (evict_word_q == `LAST_WORD) begin
                        evict_clear = 1'b1;
                        state_d = cache_pkg::c_drain;
                    end
                end
            end
            cache_pkg::c_drain: begin
                // Posted writes leave first so the fill reads current memory
                if (wb_empty && bus_idle) begin
                    if (snoop_flag_q) begin
                        snoop_done_d = 1'b1;
                        state_d = cache_pkg::c_idle;
                    end else begin
                        fill_req = 1'b1;
                        state_d = cache_pkg::c_fill;
                    end
                end
            end
            cache_pkg::c_fill: begin
                // Line becomes valid only after the fourth beat
                if (fill_done) begin
                    fill_commit = 1'b1;
                    touch_en = 1'b1;
                    state_d = cache_pkg::c_idle;
                end
            end
            default: begin
                state_d = cache_pkg::c_idle;
            end
        endcase
    end

    // Data array: fill beats and store hits never coincide
    always_ff @(posedge clk) begin
        if (fill_beat) begin
            data_q[{eline, fill_cnt_q}] <= rdata_s_q;
        end else if (arr_we) begin
            data_q[hit_waddr] <= merged;
        end
        if (fill_commit) begin
            tag_q[eline] <= miss_tag_q;
        end
    end

    // Valid per line, modified per double-word; replacement ages
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            valid_q <= '0;
            for (int i = 0; i < `LINES_TOTAL; i++) begin
                dirty_q[i] <= '0;
            end
            for (int s = 0; s < `CACHE_SETS; s++) begin
                lru_q[s] <= `AGE_RESET;
            end
        end else begin
            if (invalidate) begin
                valid_q[{lidx, snoop_serve ? hit_way : victim}] <= 1'b0;
            end
            if (fill_commit) begin
                valid_q[eline] <= 1'b1;
            end
            if (dirty_or) begin
                dirty_q[{lidx, hit_way}][lword] <= 1'b1;
            end
            if (evict_clear) begin
                dirty_q[eline] <= '0;
            end
            if (touch_en) begin
                lru_q[lru_set] <= ages_next;
            end
        end
    end

    // Controller state, miss context and core answer
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_q <= cache_pkg::c_idle;
            // Policy input sampled once per cycle
            mode_q <= 1'b0;
            miss_idx_q <= '0;
            miss_tag_q <= '0;
            miss_way_q <= '0;
            evict_word_q <= '0;
            snoop_flag_q <= 1'b0;
            core_ack_q <= 1'b0;
            core_rdata_q <= '0;
            snoop_done_q <= 1'b0;
        end else begin
            state_q <= state_d;
            mode_q <= policy_write_back;
            evict_word_q <= miss_take ? '0 : evict_next;
            if (miss_take) begin
                miss_idx_q <= lidx;
                miss_tag_q <= ltag;
                miss_way_q <= snoop_serve ? hit_way : victim;
                snoop_flag_q <= snoop_serve;
            end
            core_ack_q <= ack_d;
            if (ack_d && !core_we) begin
                core_rdata_q <= hit_data;
            end
            snoop_done_q <= snoop_done_d;
        end
    end

    // Pin synchronisers; the snoop request is edge detected after them
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rdy_m_q <= 1'b0;
            rdy_s_q <= 1'b0;
            rdata_m_q <= '0;
            rdata_s_q <= '0;
            snp_m_q <= 1'b0;
            snp_s_q <= 1'b0;
            snp_old_q <= 1'b0;
            saddr_m_q <= '0;
            saddr_s_q <= '0;
            snoop_pend_q <= 1'b0;
        end else begin
            rdy_m_q <= bus_ready;
            rdy_s_q <= rdy_m_q;
            rdata_m_q <= bus_rdata;
            rdata_s_q <= rdata_m_q;
            snp_m_q <= snoop_req;
            snp_s_q <= snp_m_q;
            snp_old_q <= snp_s_q;
            saddr_m_q <= snoop_addr;
            saddr_s_q <= saddr_m_q;
            // A new snoop wins over the clear of the one being served
            snoop_pend_q <= (snp_s_q && !snp_old_q) || (snoop_pend_q && !snoop_take);
        end
    end

    // Bus cycles: single writes from the buffer, four-beat burst reads
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            bus_clk_q <= 1'b0;
            bstate_q <= cache_pkg::b_idle;
            fill_pend_q <= 1'b0;
            fill_cnt_q <= '0;
            bus_strobe_q <= 1'b0;
            bus_write_q <= 1'b0;
            bus_burst_q <= 1'b0;
            bus_addr_q <= '0;
            bus_wdata_q <= '0;
            bus_be_q <= '0;
        end else begin
            // Divide by two; outputs move once per bus clock
            bus_clk_q <= !bus_clk_q;
            if (fill_req) begin
                fill_pend_q <= 1'b1;
            end
            if (bus_en) begin
                bus_strobe_q <= 1'b0;
                case (bstate_q)
                    cache_pkg::b_idle: begin
                        if (fill_pend_q) begin
                            // Burst of four from the line start
                            fill_pend_q <= 1'b0;
                            fill_cnt_q <= '0;
                            bus_strobe_q <= 1'b1;
                            bus_write_q <= 1'b0;
                            bus_burst_q <= 1'b1;
                            bus_addr_q <= {miss_tag_q, miss_idx_q, 4'h0};
                            bus_be_q <= `FULL_BE;
                            bstate_q <= cache_pkg::b_read;
                        end else if (wb_out_valid) begin
                            bus_strobe_q <= 1'b1;
                            bus_write_q <= 1'b1;
                            bus_burst_q <= 1'b0;
                            bus_addr_q <= wb_out[`WBUF_WIDTH-1 -: `ADDR_BITS];
                            bus_wdata_q <= wb_out[`BE_BITS +: `DATA_BITS];
                            bus_be_q <= wb_out[`BE_BITS-1:0];
                            bstate_q <= cache_pkg::b_write;
                        end
                    end
                    cache_pkg::b_write: begin
                        if (rdy_s_q) begin
                            bus_write_q <= 1'b0;
                            bstate_q <= cache_pkg::b_idle;
                        end
                    end
                    cache_pkg::b_read: begin
                        if (rdy_s_q) begin
                            fill_cnt_q <= fill_cnt_q + 1'b1;
                            if (fill_cnt_q == `LAST_WORD) begin
                                bus_burst_q <= 1'b0;
                                bstate_q <= cache_pkg::b_idle;
                            end
                        end
                    end
                    default: begin
                        bstate_q <= cache_pkg::b_idle;
                    end
                endcase
            end
        end
    end
endmodule : unified_writeback_cache

// File: cache_regs.svh
/*
  Constants of the unified write-back cache: geometry, address split,
  write buffer depth, clock ratio and reset values.
  Assumes it is included by its bare name wherever a constant is needed.
*/
`ifndef CACHE_REGS_SVH
`define CACHE_REGS_SVH

// Geometry: 8 KB, four ways, 16-byte lines, 128 sets
`define CACHE_BYTES 8192
`define CACHE_WAYS 4
`define CACHE_SETS 128
`define LINE_BYTES 16
`define LINE_WORDS 4
`define LINES_TOTAL 512
`define WORDS_TOTAL 2048

// Address split of a 32-bit physical address (4 GB space)
`define ADDR_BITS 32
`define DATA_BITS 32
`define BE_BITS 4
`define OFF_BITS 4
`define IDX_BITS 7
`define WAY_BITS 2
`define WORD_BITS 2
`define TAG_BITS 21
`define LINE_BITS 9
`define WADDR_BITS 11

// Posted write buffer
`define WBUF_DEPTH 8
`define WBUF_WIDTH 68

// Core clock is twice the bus clock
`define CLK_PERIOD_NS 10
`define CORE_PER_BUS 2

// Age reset value, last word of a line, full byte enables
`define AGE_RESET 8'hE4
`define LAST_WORD 2'h3
`define FULL_BE 4'hF

`endif

// File: cache_pkg.sv
/*
  Types of the unified write-back cache: controller and bus states.
  Assumes cache_regs.svh holds the numeric constants.
*/
package cache_pkg;

    // Cache controller states
    typedef enum logic [1:0] {
        c_idle  = 2'b00,
        c_evict = 2'b01,
        c_drain = 2'b10,
        c_fill  = 2'b11
    } cache_state_t;

    // External bus cycle states
    typedef enum logic [1:0] {
        b_idle  = 2'b00,
        b_write = 2'b01,
        b_read  = 2'b10
    } bus_state_t;

endpackage : cache_pkg

// File: write_buffer.sv
/*
  Posted write buffer: a small FIFO of address, data and byte enables.
  Assumes DEPTH is a power of two so that the pointers wrap by overflow.
*/
`timescale 1ns/100ps

module write_buffer #(
    parameter int WIDTH = 68,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic empty
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] count_q;
    logic do_push;
    logic do_pop;

    // Full and empty come straight from the occupancy count
    assign in_ready = count_q != (AW+1)'(DEPTH);
    assign out_valid = count_q != '0;
    assign empty = count_q == '0;
    assign out_data = mem_q[rd_q];
    assign do_push = in_valid && in_ready;
    assign do_pop = out_valid && out_ready;

    // Storage needs no reset: nothing is read before it is written
    always_ff @(posedge clk) begin
        if (do_push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    // Pointers and count
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            wr_q <= '0;
            rd_q <= '0;
            count_q <= '0;
        end else begin
            if (do_push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (do_pop) begin
                rd_q <= rd_q + 1'b1;
            end
            if (do_push && !do_pop) begin
                count_q <= count_q + 1'b1;
            end else if (do_pop && !do_push) begin
                count_q <= count_q - 1'b1;
            end
        end
    end
endmodule : write_buffer

// File: lru_unit.sv
/*
  Age-based least-recently-used logic for one set, purely combinational.
  Assumes the ages of a set are a permutation of 0..WAYS-1, oldest highest.
*/
`timescale 1ns/100ps

module lru_unit #(
    parameter int WAYS = 4,
    parameter int AGE_BITS = 2
) (
    input wire logic [WAYS*AGE_BITS-1:0] ages,
    input wire logic [WAYS-1:0] valid,
    input wire logic [AGE_BITS-1:0] touch_way,
    output logic [AGE_BITS-1:0] victim,
    output logic [WAYS*AGE_BITS-1:0] ages_next
);
    logic [AGE_BITS-1:0] touched_age;

    assign touched_age = ages[touch_way*AGE_BITS +: AGE_BITS];

    // Touched way becomes youngest; ways younger than it age by one
    always_comb begin
        ages_next = ages;
        for (int w = 0; w < WAYS; w++) begin
            if (w == int'(touch_way)) begin
                ages_next[w*AGE_BITS +: AGE_BITS] = '0;
            end else if (ages[w*AGE_BITS +: AGE_BITS] < touched_age) begin
                ages_next[w*AGE_BITS +: AGE_BITS] = ages[w*AGE_BITS +: AGE_BITS] + 1'b1;
            end
        end
    end

    // An empty way is filled before any live line is displaced
    always_comb begin
        victim = '0;
        for (int w = WAYS - 1; w >= 0; w--) begin
            if (ages[w*AGE_BITS +: AGE_BITS] == AGE_BITS'(WAYS - 1)) begin
                victim = AGE_BITS'(w);
            end
        end
        for (int w = WAYS - 1; w >= 0; w--) begin
            if (!valid[w]) begin
                victim = AGE_BITS'(w);
            end
        end
    end
endmodule : lru_unit

// File: cache_chk.sv
/* Checker on the cache's core and bus pins.
   Assumes a bind to the top module; sees its ports only. */
`timescale 1ns/100ps

module cache_chk (
    input wire logic clk,
    input wire logic reset,
    input wire logic core_req,
    input wire logic core_ack_q,
    input wire logic bus_clk_q,
    input wire logic bus_strobe_q,
    input wire logic bus_write_q,
    input wire logic bus_burst_q,
    input wire logic [31:0] bus_addr_q
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);

    property p_ack_req; core_ack_q |-> $past(core_req); endproperty
    a_ack_req: assert property (p_ack_req) else $error("ack w/o req");
    property p_bus_clk; 1'b1 |=> $changed(bus_clk_q); endproperty
    a_bus_clk: assert property (p_bus_clk) else $error("bclk stuck");
    property p_strobe_ph; $rose(bus_strobe_q) |-> !bus_clk_q; endproperty
    a_strobe_ph: assert property (p_strobe_ph) else $error("strobe phase");
    property p_strobe_len; $rose(bus_strobe_q) |=> bus_strobe_q ##1 !bus_strobe_q; endproperty
    a_strobe_len: assert property (p_strobe_len) else $error("strobe len");
    property p_wr_hold; bus_write_q && $past(bus_write_q) |-> $stable(bus_addr_q); endproperty
    a_wr_hold: assert property (p_wr_hold) else $error("wr moved");
    property p_burst; bus_burst_q |-> !bus_write_q && bus_addr_q[3:0] == 4'h0; endproperty
    a_burst: assert property (p_burst) else $error("bad burst");
    property p_bu_hold; bus_burst_q && $past(bus_burst_q) |-> $stable(bus_addr_q); endproperty
    a_bu_hold: assert property (p_bu_hold) else $error("burst moved");
    // four beats; synced ready means six cycles at least
    property p_bu_len; $rose(bus_burst_q) |=> bus_burst_q [*6]; endproperty
    a_bu_len: assert property (p_bu_len) else $error("burst short");
endmodule : cache_chk

bind unified_writeback_cache cache_chk cache_chk_inst (.clk, .reset, .core_req, .core_ack_q, .bus_clk_q,
    .bus_strobe_q, .bus_write_q, .bus_burst_q, .bus_addr_q);

// File: mem_model.sv
/* Memory on the far side of the cache bus.
   Assumes one strobe per cycle and four beats per burst. */
`timescale 1ns/100ps

module mem_model (
    input wire logic clk,
    input wire logic bus_strobe_q,
    input wire logic bus_write_q,
    input wire logic bus_burst_q,
    input wire logic [31:0] bus_addr_q,
    input wire logic [31:0] bus_wdata_q,
    input wire logic [3:0] bus_be_q,
    input wire logic [3:0] lat,
    output logic bus_ready,
    output logic [31:0] bus_rdata
);
    logic [31:0] mem [logic [31:0]];
    logic [31:0] a, w;
    int writes = 0;

    // one word per ready, beats in order; unwritten words read as their address
    initial begin
        {bus_ready, bus_rdata} = '0;
        forever begin
            @(negedge clk);
            if (bus_strobe_q) for (int b = 0; b < (bus_burst_q ? 4 : 1); b++) begin
                repeat (lat + 1) @(negedge clk);
                a = {bus_addr_q[31:4], bus_burst_q ? b[1:0] : bus_addr_q[3:2], 2'h0};
                w = mem.exists(a) ? mem[a] : a;
                for (int i = 0; i < 4; i++) if (bus_write_q && bus_be_q[i]) w[8*i+:8] = bus_wdata_q[8*i+:8];
                if (bus_write_q) writes++;
                mem[a] = w;
                {bus_ready, bus_rdata} = {1'h1, w};
                repeat (2) @(negedge clk);
                // Released data flips so a stale word is never taken as a beat
                {bus_ready, bus_rdata} = {1'h0, ~w};
            end
        end
    end
endmodule : mem_model

// File: unified_writeback_cache_bench.sv
/* Bench of the cache: directed and random core traffic.
   Assumes mem_model answers the bus. */
`timescale 1ns/100ps

module unified_writeback_cache_bench;
    logic clk = 1'h0, reset = 1'h1, policy_write_back = 1'h0, core_req = 1'h0, core_we = 1'h0, snoop_req = 1'h0;
    logic [31:0] core_addr = '0, core_wdata = '0, r = 32'h3254938B, a0 = 32'h10328;
    logic [3:0] core_be = '0, lat = '0, bus_be_q;
    logic core_ack_q, bus_clk_q, bus_strobe_q, bus_write_q, bus_burst_q, bus_ready, snoop_done_q;
    logic [31:0] core_rdata_q, bus_addr_q, bus_wdata_q, bus_rdata, shadow [logic [31:0]];
    int num_errors = 0, checks_done = 0, w0, n;

    // Core clock; the other master only ever snoops the first test line
    always #5 clk = ~clk;
    unified_writeback_cache unified_writeback_cache_inst (.clk, .reset, .policy_write_back, .core_req, .core_we,
        .core_addr, .core_wdata, .core_be, .core_ack_q, .core_rdata_q, .bus_clk_q, .bus_strobe_q, .bus_write_q,
        .bus_burst_q, .bus_addr_q, .bus_wdata_q, .bus_be_q, .bus_ready, .bus_rdata, .snoop_req,
        .snoop_addr(a0), .snoop_done_q);
    mem_model mem_model_inst (.clk, .bus_strobe_q, .bus_write_q, .bus_burst_q, .bus_addr_q, .bus_wdata_q,
        .bus_be_q, .lat, .bus_ready, .bus_rdata);

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    task automatic check(input string name, input logic [31:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s exp %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic results;
        if (num_errors == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : results

    // One access held to its ack; hit 2 leaves the latency unchecked
    task automatic access(input logic we, input logic [31:0] a, input logic [3:0] be, input logic [1:0] hit);
        logic [31:0] w;
        w = shadow.exists(a) ? shadow[a] : a;
        // One edge with the request low, so back-to-back calls never retake it
        @(negedge clk);
        {core_req, core_we, core_addr, core_wdata, core_be} = {1'h1, we, a, r, be};
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (core_ack_q !== 1'h1 && n < 400);
        core_req = 1'h0;
        if (n == 400) begin
            num_errors++;
            results();
        end
        for (int i = 0; i < 4; i++) if (we && be[i]) w[8*i+:8] = r[8*i+:8];
        if (we) shadow[a] = w;
        else check("rdata", core_rdata_q, w);
        if (!hit[1]) check("hit", n <= 2, hit[0]);
        r = lfsr(r);
    endtask : access

    // Reset, then fills, snoop flush of a dirty word, write-through, random traffic
    initial begin
        repeat (2) @(negedge clk);
        reset = 1'h0;
        for (int i = 0; i < 4; i++) access(0, a0 + i * 32'h800, 0, 0);
        policy_write_back = 1'h1;
        @(negedge clk);
        w0 = mem_model_inst.writes;
        access(1, a0, 4'h6, 1);
        // Snoop of the dirty line: one word written back, line dropped
        snoop_req = 1'h1;
        n = 0;
        while (snoop_done_q !== 1'h1 && n < 400) begin
            @(negedge clk);
            n++;
        end
        check("snoop_done", snoop_done_q, 1);
        check("snoop_writes", mem_model_inst.writes - w0, 1);
        if (n == 400) results();
        for (int i = 1; i < 5; i++) access(0, a0 + i * 32'h800, 0, i < 4);
        check("wb_writes", mem_model_inst.writes - w0, 1);
        access(0, a0, 0, 0);
        policy_write_back = 1'h0;
        @(negedge clk);
        w0 = mem_model_inst.writes;
        access(1, 32'h20040, 4'hF, 2);
        access(1, a0, 4'h9, 2);
        access(0, 32'h20040, 0, 0);
        check("wt_writes", mem_model_inst.writes - w0, 2);
        repeat (60) begin
            lat = {2'h0, r[9:8]};
            policy_write_back = r[7];
            access(r[6], {18'h0, r[13:11], 7'h05, r[5:4], 2'h0}, r[3:0] | 4'h1, 2);
        end
        results();
    end
endmodule : unified_writeback_cache_bench
